// *** rtl/sequencer_pkg.sv ***
// constants and types shared by the program control sequencer
package sequencer_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CODE_W = 8;
	localparam int PC_W = 9;
	localparam int SP_W = 4;
	localparam int STACK_DEPTH = 16;
	localparam int COND_COUNT = 30;
	localparam int EVOKE_COUNT = 192;
	localparam logic [PC_W-1:0] PC_RESET = 9'h000;
	localparam logic [SP_W-1:0] SP_RESET = 4'h0;
	localparam logic [CODE_W-1:0] CODE_FIRST_JUMP = 8'hC0;
	localparam logic [CODE_W-1:0] CODE_FIRST_STACK = 8'hFC;
	localparam int FIELD_MBIT = 0;
	localparam int FIELD_RETURN = 1;
	localparam int FIELD_COND_LO = 1;
	localparam int FIELD_COND_HI = 5;
	// fetch busy one-shot, start delay and completion pulse, in ns
	localparam int FETCH_BUSY_NS = 500;
	localparam int START_DELAY_NS = 1000;
	localparam int DONE_PULSE_NS = 100;
	localparam int FETCH_BUSY_CYCLES = (FETCH_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int START_DELAY_CYCLES = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DONE_PULSE_CYCLES = (DONE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 8;

	typedef enum logic [2:0] {
		st_fetch,
		st_skip,
		st_push,
		st_transfer,
		st_return,
		st_test_true,
		st_fetch_addr,
		st_load_pc
	} seq_state_type;

	typedef enum logic [1:0] {
		cls_evoke,
		cls_test,
		cls_call,
		cls_exit
	} code_class_type;
endpackage

// *** rtl/return_stack.sv ***
// return address stack memory with registered read data
`timescale 1ns/10ps
module return_stack #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	parameter int ADDR_W = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule // return_stack

// *** rtl/program_control_sequencer.sv ***
// program control sequencer: fetch, decode, state generator, pc and stack
`timescale 1ns/10ps
module program_control_sequencer
	import sequencer_pkg::*;
#(
	parameter int COND_N = sequencer_pkg::COND_COUNT,
	parameter int EVOKE_N = sequencer_pkg::EVOKE_COUNT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic power_clear,
	input wire logic start,
	output logic run_indicator,
	output logic fetch_request,
	output logic [sequencer_pkg::PC_W-1:0] fetch_addr,
	input wire logic [sequencer_pkg::CODE_W-1:0] fetch_data,
	output logic decode_enable_strobe,
	output logic [7:0] state_onehot,
	input wire logic [COND_N-1:0] first_conditions,
	input wire logic [COND_N-1:0] second_conditions,
	input wire logic first_condition_select,
	input wire logic second_condition_select,
	output logic second_selected,
	output logic transfer_active,
	output logic [sequencer_pkg::CODE_W-1:0] evoke_code,
	output logic [EVOKE_N-1:0] evoke_strobes,
	input wire logic data_ready,
	input wire logic data_accept,
	output logic transfer_done
);
	import sequencer_pkg::*;

	localparam logic [TIMER_W-1:0] BUSY_LOAD = TIMER_W'(FETCH_BUSY_CYCLES);
	localparam logic [TIMER_W-1:0] DELAY_LOAD = TIMER_W'(START_DELAY_CYCLES);
	localparam logic [TIMER_W-1:0] DONE_LOAD = TIMER_W'(DONE_PULSE_CYCLES);

	function automatic code_class_type code_class(input logic [CODE_W-1:0] code);
		if (code < CODE_FIRST_JUMP) begin
			code_class = cls_evoke;
		end else if (code < CODE_FIRST_STACK) begin
			code_class = cls_test;
		end else if (!code[FIELD_RETURN]) begin
			code_class = cls_call;
		end else begin
			code_class = cls_exit;
		end
	endfunction

	// pin synchronisers
	logic pclr_s1_r, pclr_s2_r, start_s1_r, start_s2_r, start_prev_r;
	logic ready_s1_r, ready_s2_r, accept_s1_r, accept_s2_r;
	logic [COND_N-1:0] cond0_s1_r, cond0_s2_r, cond1_s1_r, cond1_s2_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pclr_s1_r <= 1'b0;
			pclr_s2_r <= 1'b0;
			start_s1_r <= 1'b0;
			start_s2_r <= 1'b0;
			start_prev_r <= 1'b0;
			ready_s1_r <= 1'b0;
			ready_s2_r <= 1'b0;
			accept_s1_r <= 1'b0;
			accept_s2_r <= 1'b0;
			cond0_s1_r <= '0;
			cond0_s2_r <= '0;
			cond1_s1_r <= '0;
			cond1_s2_r <= '0;
		end else begin
			pclr_s1_r <= power_clear;
			pclr_s2_r <= pclr_s1_r;
			start_s1_r <= start;
			start_s2_r <= start_s1_r;
			start_prev_r <= start_s2_r;
			ready_s1_r <= data_ready;
			ready_s2_r <= ready_s1_r;
			accept_s1_r <= data_accept;
			accept_s2_r <= accept_s1_r;
			cond0_s1_r <= first_conditions;
			cond0_s2_r <= cond0_s1_r;
			cond1_s1_r <= second_conditions;
			cond1_s2_r <= cond1_s1_r;
		end
	end

	logic clear;
	logic start_pulse;
	assign clear = !rst_n || pclr_s2_r;
	assign start_pulse = start_s2_r && !start_prev_r;

	seq_state_type state_r, state_nxt;
	logic [PC_W-1:0] pc_r;
	logic [SP_W-1:0] sp_r;
	logic [CODE_W-1:0] code_r;
	logic [CODE_W-1:0] jump_lo_r;
	logic m_bit_r;
	logic run_r;
	logic [TIMER_W-1:0] fetch_busy_timer;
	logic [TIMER_W-1:0] delay_r;
	logic [TIMER_W-1:0] done_cnt_r;
	logic done_r, active_r, sel2_r, ready_seen_r, accept_seen_r;
	logic step;
	logic cond_true;
	logic [4:0] cond_idx;
	code_class_type cls;
	logic [PC_W-1:0] stack_rdata;

	// clock gate: runs only when timer recovered and no transfer or done pending
	assign step = run_r && fetch_busy_timer == '0 && !active_r && !done_r;

	assign decode_enable_strobe = step && state_r == st_fetch;
	assign fetch_request = run_r && (state_r == st_fetch || state_r == st_fetch_addr);

	// combinational decoder over fetched code and selected condition
	assign cls = code_class(fetch_data);
	assign cond_idx = fetch_data[FIELD_COND_HI:FIELD_COND_LO];
	always_comb begin
		cond_true = 1'b0;
		if (cond_idx == 5'h00) begin
			cond_true = 1'b1;
		end else if (32'(cond_idx) < COND_N) begin
			cond_true = sel2_r ? cond1_s2_r[cond_idx] : cond0_s2_r[cond_idx];
		end
	end

	// feedback logic with jam set from decoder
	always_comb begin
		state_nxt = st_fetch;
		case (state_r)
			st_fetch: begin
				case (cls)
					cls_evoke: state_nxt = st_transfer;
					cls_test: state_nxt = cond_true ? st_test_true : st_skip;
					cls_call: state_nxt = st_push;
					cls_exit: state_nxt = st_return;
					default: state_nxt = st_fetch;
				endcase
			end
			st_skip: state_nxt = st_transfer;
			st_push: state_nxt = st_test_true;
			st_transfer: state_nxt = st_fetch;
			st_return: state_nxt = st_skip;
			st_test_true: state_nxt = st_fetch_addr;
			st_fetch_addr: state_nxt = st_load_pc;
			st_load_pc: state_nxt = st_fetch;
			default: state_nxt = st_fetch;
		endcase
	end

	always_ff @(posedge clk) begin
		if (clear || start_pulse) begin
			state_r <= st_fetch;
		end else if (step) begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (clear) begin
			state_onehot <= 8'h01;
		end else begin
			state_onehot <= 8'h01 << state_r;
		end
	end

	// program counter
	always_ff @(posedge clk) begin
		if (clear || start_pulse) begin
			pc_r <= PC_RESET;
		end else if (step) begin
			case (state_r)
				st_skip, st_transfer, st_test_true: pc_r <= pc_r + 9'h001;
				st_return: pc_r <= stack_rdata;
				st_load_pc: pc_r <= {m_bit_r, jump_lo_r};
				default: pc_r <= pc_r;
			endcase
		end
	end
	assign fetch_addr = pc_r;

	// instruction, memory-half bit and jump address capture
	always_ff @(posedge clk) begin
		if (clear) begin
			code_r <= '0;
			m_bit_r <= 1'b0;
			jump_lo_r <= '0;
		end else if (step) begin
			if (state_r == st_fetch) begin
				code_r <= fetch_data;
			end
			if (state_r == st_test_true) begin
				m_bit_r <= code_r[FIELD_MBIT];
			end
			if (state_r == st_fetch_addr) begin
				jump_lo_r <= fetch_data;
			end
		end
	end

	// stack pointer: up after push, down before return read, wraps freely
	always_ff @(posedge clk) begin
		if (clear) begin
			sp_r <= SP_RESET;
		end else if (step && state_r == st_push) begin
			sp_r <= sp_r + 4'h1;
		end else if (decode_enable_strobe && cls == cls_exit) begin
			sp_r <= sp_r - 4'h1;
		end
	end

	return_stack #(
		.WIDTH(PC_W),
		.DEPTH(STACK_DEPTH),
		.ADDR_W(SP_W)
	) u_stack (
		.clk(clk),
		.rst_n(rst_n),
		.wr_en(step && state_r == st_push),
		.wr_addr(sp_r),
		.wr_data(pc_r),
		.rd_addr(sp_r - 4'h1),
		.rd_data(stack_rdata)
	);

	// start delay and run indicator
	always_ff @(posedge clk) begin
		if (clear) begin
			run_r <= 1'b0;
			delay_r <= '0;
		end else if (start_pulse) begin
			run_r <= 1'b0;
			delay_r <= DELAY_LOAD;
		end else if (delay_r != '0) begin
			delay_r <= delay_r - 8'h01;
			run_r <= delay_r == 8'h01;
		end
	end
	assign run_indicator = run_r;

	// fetch busy one-shot
	always_ff @(posedge clk) begin
		if (clear) begin
			fetch_busy_timer <= '0;
		end else if (start_pulse) begin
			fetch_busy_timer <= BUSY_LOAD;
		end else if (step && (state_nxt == st_fetch || state_nxt == st_fetch_addr)) begin
			fetch_busy_timer <= BUSY_LOAD;
		end else if (fetch_busy_timer != '0) begin
			fetch_busy_timer <= fetch_busy_timer - 8'h01;
		end
	end

	// condition set select, first after reset
	always_ff @(posedge clk) begin
		if (clear) begin
			sel2_r <= 1'b0;
		end else if (second_condition_select) begin
			sel2_r <= 1'b1;
		end else if (first_condition_select) begin
			sel2_r <= 1'b0;
		end
	end
	assign second_selected = sel2_r;

	// transfer flop, only evoke codes start it
	always_ff @(posedge clk) begin
		if (clear) begin
			active_r <= 1'b0;
			evoke_code <= '0;
		end else if (decode_enable_strobe && cls == cls_evoke) begin
			active_r <= 1'b1;
			evoke_code <= fetch_data;
		end else if (active_r && ready_seen_r && accept_seen_r) begin
			active_r <= 1'b0;
		end
	end
	assign transfer_active = active_r;

	// handshake: ready then accept, completion after both
	always_ff @(posedge clk) begin
		if (clear || !active_r) begin
			ready_seen_r <= 1'b0;
			accept_seen_r <= 1'b0;
		end else begin
			if (ready_s2_r) begin
				ready_seen_r <= 1'b1;
			end
			if (accept_s2_r && ready_seen_r) begin
				accept_seen_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clear) begin
			done_r <= 1'b0;
			done_cnt_r <= '0;
		end else if (active_r && ready_seen_r && accept_seen_r) begin
			done_r <= 1'b1;
			done_cnt_r <= DONE_LOAD;
		end else if (done_cnt_r != '0) begin
			done_cnt_r <= done_cnt_r - 8'h01;
			done_r <= done_cnt_r != 8'h01;
		end
	end
	assign transfer_done = done_r;

	// one evoke strobe per transfer code while the flop is set
	genvar gi;
	generate
		for (gi = 0; gi < EVOKE_N; gi++) begin : g_evoke
			assign evoke_strobes[gi] = active_r && 32'(evoke_code) == gi;
		end
	endgenerate
endmodule // program_control_sequencer

// *** sim/far_side.sv ***
// control memory and data module model on the far side of the sequencer
`timescale 1ns/10ps
module far_side (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic [8:0] fetch_addr,
	output logic [7:0] fetch_data,
	input wire logic [191:0] evoke_strobes,
	output logic data_ready,
	output logic data_accept
);
	logic [7:0] rom_r [0:511];
	logic [3:0] wait_r;
	initial begin
		wait_r = 4'h0;
		data_ready = 1'b0;
		data_accept = 1'b0;
		for (int i = 0; i < 512; i++)
			rom_r[i] = 8'hC0;
		rom_r[9'h000] = 8'h05;
		rom_r[9'h001] = 8'hC2;
		rom_r[9'h003] = 8'hC1;
		rom_r[9'h004] = 8'h10;
		rom_r[9'h110] = 8'hFC;
		rom_r[9'h111] = 8'h20;
		rom_r[9'h020] = 8'hBF;
		rom_r[9'h021] = 8'hFE;
		rom_r[9'h112] = 8'hC4;
		rom_r[9'h113] = 8'h40;
		rom_r[9'h040] = 8'hC0;
		rom_r[9'h041] = 8'h42;
		rom_r[9'h042] = 8'hC4;
	end
	assign fetch_data = rom_r[fetch_addr];
	// source answers first, destination later; slow stretches the load
	always @(posedge clk) begin
		if (!rst_n || evoke_strobes == '0) begin
			wait_r <= 4'h0;
			data_ready <= 1'b0;
			data_accept <= 1'b0;
		end else begin
			if (wait_r != 4'hF)
				wait_r <= wait_r + 4'h1;
			data_ready <= wait_r >= 4'h2;
			data_accept <= wait_r >= (slow ? 4'hC : 4'h6);
		end
	end
endmodule // far_side

// *** sim/program_control_sequencer_sva.sv ***
// assertions on the program control sequencer ports
`timescale 1ns/10ps
module program_control_sequencer_check #(
	parameter int EVOKE_N = 192
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic power_clear,
	input wire logic run_indicator,
	input wire logic fetch_request,
	input wire logic [8:0] fetch_addr,
	input wire logic decode_enable_strobe,
	input wire logic [7:0] state_onehot,
	input wire logic first_condition_select,
	input wire logic second_condition_select,
	input wire logic second_selected,
	input wire logic transfer_active,
	input wire logic [7:0] evoke_code,
	input wire logic [EVOKE_N-1:0] evoke_strobes,
	input wire logic data_ready,
	input wire logic data_accept,
	input wire logic transfer_done
);
	logic rdy_r;
	logic acc_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || power_clear);
	// handshake history since the last decode
	always_ff @(posedge clk) begin
		if (!rst_n || decode_enable_strobe) begin
			rdy_r <= 1'b0;
			acc_r <= 1'b0;
		end else begin
			rdy_r <= rdy_r | data_ready;
			acc_r <= acc_r | (rdy_r & data_accept);
		end
	end
	property p_oh; $onehot(state_onehot); endproperty
	a_oh: assert property (p_oh) else $error("state not one-hot");
	property p_to0; $rose(state_onehot[0]) |-> $past(state_onehot[3]) || $past(state_onehot[7]); endproperty
	a_to0: assert property (p_to0) else $error("bad entry to state 0");
	property p_dec; decode_enable_strobe |-> fetch_request && run_indicator; endproperty
	a_dec: assert property (p_dec) else $error("decode outside fetch");
	property p_busy; $rose(fetch_request) && $past(run_indicator) |-> !decode_enable_strobe[*8]; endproperty
	a_busy: assert property (p_busy) else $error("step while timer busy");
	property p_run; $rose(run_indicator) |-> fetch_addr == 9'h000 && fetch_request; endproperty
	a_run: assert property (p_run) else $error("run without cleared pc");
	property p_evk; evoke_strobes == (transfer_active ? ({{(EVOKE_N-1){1'b0}}, 1'b1} << evoke_code) : '0); endproperty
	a_evk: assert property (p_evk) else $error("evoke strobes wrong");
	property p_hs; $rose(transfer_done) |-> rdy_r && acc_r; endproperty
	a_hs: assert property (p_hs) else $error("done before handshake");
	property p_done; $rose(transfer_done) |-> !transfer_active ##0 transfer_done[*4] ##1 !transfer_done; endproperty
	a_done: assert property (p_done) else $error("done pulse wrong");
	property p_sel2; second_condition_select |=> second_selected; endproperty
	a_sel2: assert property (p_sel2) else $error("second set not selected");
	property p_sel1; first_condition_select && !second_condition_select |=> !second_selected; endproperty
	a_sel1: assert property (p_sel1) else $error("first set not selected");
	property p_pwr; disable iff (!rst_n) power_clear[*3] |=> fetch_addr == 9'h000 && !run_indicator; endproperty
	a_pwr: assert property (p_pwr) else $error("power clear ignored");
endmodule // program_control_sequencer_check
bind program_control_sequencer program_control_sequencer_check #(.EVOKE_N(EVOKE_N)) u_chk (
	.clk, .rst_n, .power_clear, .run_indicator, .fetch_request, .fetch_addr,
	.decode_enable_strobe, .state_onehot, .first_condition_select, .second_condition_select,
	.second_selected, .transfer_active, .evoke_code, .evoke_strobes, .data_ready,
	.data_accept, .transfer_done
);

// *** sim/tb_program_control_sequencer.sv ***
// self-checking testbench for the program control sequencer
`timescale 1ns/10ps
module tb_program_control_sequencer;
	import sequencer_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic power_clear = 1'b0;
	logic start = 1'b0;
	logic slow = 1'b0;
	logic first_condition_select = 1'b0;
	logic second_condition_select = 1'b0;
	logic [29:0] first_conditions = 30'h0000_0004;
	logic [29:0] second_conditions = 30'h3FFF_FFFB;
	logic run_indicator;
	logic fetch_request;
	logic [8:0] fetch_addr;
	logic [7:0] fetch_data;
	logic decode_enable_strobe;
	logic [7:0] state_onehot;
	logic second_selected;
	logic transfer_active;
	logic [7:0] evoke_code;
	logic [191:0] evoke_strobes;
	logic data_ready;
	logic data_accept;
	logic transfer_done;
	int mismatches = 0;
	int checks_done = 0;
	logic [8:0] exp_pc [10] = '{9'h000, 9'h001, 9'h003, 9'h110, 9'h020, 9'h021, 9'h112, 9'h040,
		9'h042, 9'h044};
	always #12.5 clk = ~clk;
	program_control_sequencer u_dut (.clk, .rst_n, .power_clear, .start, .run_indicator,
		.fetch_request, .fetch_addr, .fetch_data, .decode_enable_strobe, .state_onehot,
		.first_conditions, .second_conditions, .first_condition_select,
		.second_condition_select, .second_selected, .transfer_active, .evoke_code,
		.evoke_strobes, .data_ready, .data_accept, .transfer_done);
	far_side u_far (.clk, .rst_n, .slow, .fetch_addr, .fetch_data, .evoke_strobes, .data_ready,
		.data_accept);
	task automatic check(input logic [191:0] seen, input logic [191:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// bounded wait for a decode strobe or a completion pulse
	task automatic await(input logic done);
		for (int n = 0; n < 1000; n++) begin
			@(negedge clk);
			if ((done ? transfer_done : decode_enable_strobe) === 1'b1)
				return;
		end
		mismatches++;
		$display("mismatch at %0t: wait timed out", $time);
		end_of_test();
	endtask
	task automatic pulse_select(input logic second);
		@(posedge clk);
		first_condition_select <= !second;
		second_condition_select <= second;
		@(posedge clk);
		first_condition_select <= 1'b0;
		second_condition_select <= 1'b0;
		@(negedge clk);
		check(second_selected, second);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		pulse_select(1'b1);
		pulse_select(1'b0);
		check(run_indicator, 1'b0);
		@(posedge clk);
		start <= 1'b1;
		repeat (4) @(posedge clk);
		start <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			slow <= (i > 1);
			await(1'b0);
			check(fetch_addr, exp_pc[i]);
			if (i == 0)
				check(run_indicator, 1'b1);
			// second set: the same condition 2 test must now skip
			if (i == 7)
				pulse_select(1'b1);
			if (i == 0 || i == 4) begin
				@(negedge clk);
				check(transfer_active, 1'b1);
				check(evoke_strobes, 192'h1 << ((i == 0) ? 5 : 191));
				await(1'b1);
				check(transfer_active, 1'b0);
			end
		end
		@(posedge clk);
		power_clear <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		check(fetch_addr, 9'h000);
		check(state_onehot, 8'h01);
		check(run_indicator, 1'b0);
		end_of_test();
	end
endmodule // tb_program_control_sequencer
